// ### msc_pkg.sv
// Purpose: shared constants and types of the muting sequencer
// Assumes: 20 MHz system clock, all timing kept in 1 ms ticks
// Notes: selectable limits are plain defaults, not fixed figures
package msc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam int MS_W = 27;
  localparam int EL_W = 13;
  localparam int SENS_N = 4;
  localparam int MODE_W = 2;
  localparam int TSEL_W = 2;
  localparam int SYNC_W = 15;

  // times in ms, each one tick of the divider
  localparam logic [EL_W-1:0] CROSS_WIN_MS = 13'd2000;
  localparam logic [EL_W-1:0] MUTE_LAT_MS = 13'd100;
  localparam logic [EL_W-1:0] PAR_MIN_MS = 13'd300;
  localparam logic [EL_W-1:0] PAR_MAX_MS = 13'd5000;
  localparam logic [EL_W-1:0] CROSS_GRACE_MS = 13'd2000;
  localparam logic [EL_W-1:0] PAR_GRACE_MS = 13'd5000;
  localparam logic [MS_W-1:0] LIMIT_24H_MS = 27'd86400000;
  localparam logic [MS_W-1:0] SEL_LIMIT0_MS = 27'd60000;
  localparam logic [MS_W-1:0] SEL_LIMIT1_MS = 27'd600000;
  localparam logic [MS_W-1:0] SEL_LIMIT2_MS = 27'd3600000;
  localparam logic [MS_W-1:0] SEL_LIMIT3_MS = 27'd28800000;

  localparam logic [SENS_N-1:0] USED2_MASK = 4'h3;
  localparam logic [SENS_N-1:0] USED4_MASK = 4'hF;
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h0000;

  typedef enum logic [1:0] {
    MODE_CROSSED = 2'h0,
    MODE_PAR2 = 2'h1,
    MODE_PAR4 = 2'h2,
    MODE_BAD = 2'h3
  } msc_mode_t;

  // gray along idle, arming, muted, grace, clear wait
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARMING = 3'h1,
    ST_MUTED = 3'h3,
    ST_GRACE = 3'h2,
    ST_CLEARWAIT = 3'h6,
    ST_TRIP = 3'h7,
    ST_BLOCKED = 3'h5
  } msc_state_t;
endpackage : msc_pkg

// ### msc_sequencer.sv
// Purpose: muting sequencer of a light curtain receiver
// Assumes: sensor and beam inputs are asynchronous active-high pins
// Notes: one clock; slow timing runs on a 1 ms enable pulse
`timescale 1ns/1ns
// How it works
// R1 - external sensor drives high when active
// R2 - optical sensor high while beam blocked
// R3 - end muting after 24 hours
// R4 - selectable variant uses time-select limit
// R5 - crossed: both sensors within 2 s
// R6 - beams suppressed within 100 ms
// R7 - crossed: any release ends muting
// R8 - crossed: protection back in 2 s
// R9 - override restores after trip
// R10 - two parallel: sensor 1 then 2
// R11 - two parallel gap 0.3 to 5 s
// R12 - two parallel: release 1 then 2
// R13 - two parallel: 5 s grace, then check
// R14 - four parallel: order 1234 or 4321
// R15 - four parallel first gap 0.3-5 s
// R16 - four parallel: release in order
// R17 - no new muting before previous ends
// R18 - same sensors start and end muting
// R19 - sensor fault blocks, outputs off
// R20 - external, internal or combined sensors
// R21 - permit input must be high
// R22 - bad order or timing: no muting
module msc_sequencer #(
  parameter int TICK_CYC = msc_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic mute_sensor_a_in,
  input wire logic mute_sensor_b_in,
  input wire logic [msc_pkg::SENS_N-1:0] arm_sensor_in,
  input wire logic mute_permit_in,
  input wire logic beam_blocked_in,
  input wire logic sensor_fault_in,
  input wire logic override_in,
  input wire logic [msc_pkg::MODE_W-1:0] config_mode_in,
  input wire logic selectable_time_in,
  input wire logic [msc_pkg::TSEL_W-1:0] time_select_in,
  output logic [1:0] safety_output_out,
  output logic muting_out,
  output logic fault_out
);
  import msc_pkg::*;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [31:0] tick_cnt;
  logic tick;
  msc_state_t state;
  msc_state_t next_state;
  logic [2:0] pos;
  logic [2:0] next_pos;
  logic dir;
  logic next_dir;
  logic restart;
  logic [EL_W-1:0] elapsed;
  logic [MS_W-1:0] mute_ms;
  logic [MS_W-1:0] limit_ms;
  logic [SENS_N-1:0] act;
  logic [SENS_N-1:0] used;
  logic [SENS_N-1:0] rel;
  logic [2:0] seq_n;
  logic four;
  logic crossed;
  logic permit;
  logic beam;
  logic fault;
  logic ovr;
  logic sel_var;
  msc_mode_t mode;
  logic [TSEL_W-1:0] tsel;
  logic [EL_W-1:0] grace_ms;
  logic next_on;

  // prefix of the sequence, forward or reverse
  function automatic logic [SENS_N-1:0] seq_mask(input logic [2:0] p,
      input logic rev, input logic f4);
    logic [SENS_N-1:0] m;
    m = 4'h0;
    for (int i = 0; i < SENS_N; i++) begin
      if (i < int'(p)) begin
        if (!rev) begin
          m[i] = 1'b1;
        end else if (f4) begin
          m[3-i] = 1'b1;
        end else if (i < 2) begin
          m[1-i] = 1'b1;
        end
      end
    end
    return m;
  endfunction : seq_mask

  // two-flop synchroniser for all pins
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= {selectable_time_in, config_mode_in, time_select_in,
                override_in, sensor_fault_in, beam_blocked_in,
                mute_permit_in, arm_sensor_in, mute_sensor_b_in,
                mute_sensor_a_in};
      sync2 <= sync1;
    end
  end

  assign sel_var = sync2[14];
  assign mode = msc_mode_t'(sync2[13:12]);
  assign tsel = sync2[11:10];
  assign ovr = sync2[9];
  assign fault = sync2[8];
  assign beam = sync2[7];
  assign permit = sync2[6];
  assign four = (mode == MODE_PAR4);
  assign crossed = (mode == MODE_CROSSED);
  assign used = four ? USED4_MASK : USED2_MASK;
  assign seq_n = four ? 3'd4 : 3'd2;
  // R1 R2 high level counts as asserted
  // R20 external ored onto arm sensors
  assign act = {sync2[5], sync2[4], sync2[3] | sync2[1],
                sync2[2] | sync2[0]} & used;
  assign rel = ~act & used;
  assign grace_ms = crossed ? CROSS_GRACE_MS : PAR_GRACE_MS;

  // R3 R4 muting duration limit
  always_comb begin
    limit_ms = LIMIT_24H_MS;
    if (sel_var) begin
      case (tsel)
        2'h0: limit_ms = SEL_LIMIT0_MS;
        2'h1: limit_ms = SEL_LIMIT1_MS;
        2'h2: limit_ms = SEL_LIMIT2_MS;
        default: limit_ms = SEL_LIMIT3_MS;
      endcase
    end
  end

  // 1 ms enable
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_CYC - 1)) begin
      tick_cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    next_pos = pos;
    next_dir = dir;
    restart = 1'b0;
    case (state)
      ST_IDLE: begin
        // R21 R22 bad first sensor waits for clear
        if (act != 4'h0) begin
          restart = 1'b1;
          next_pos = 3'd1;
          if (!permit) begin
            next_state = ST_CLEARWAIT;
          end else if (crossed && act == USED2_MASK) begin
            next_state = ST_MUTED;
            next_pos = 3'd0;
          end else if (act == seq_mask(3'd1, 1'b0, four)) begin
            next_state = ST_ARMING;
            next_dir = 1'b0;
          end else if (mode != MODE_PAR2 &&
                       act == seq_mask(3'd1, 1'b1, four)) begin
            // R10 reverse start refused on two parallel
            next_state = ST_ARMING;
            next_dir = 1'b1;
          end else begin
            next_state = ST_CLEARWAIT;
          end
        end
      end
      ST_ARMING: begin
        // R5 R11 R15 R14 order and window
        if (!permit) begin
          next_state = ST_CLEARWAIT;
        end else if (pos == 3'd1 && crossed && elapsed > CROSS_WIN_MS) begin
          next_state = ST_CLEARWAIT;
        end else if (pos == 3'd1 && !crossed && elapsed > PAR_MAX_MS) begin
          next_state = ST_CLEARWAIT;
        end else if (act == seq_mask(pos + 3'd1, dir, four)) begin
          if (pos == 3'd1 && !crossed && elapsed < PAR_MIN_MS) begin
            next_state = ST_CLEARWAIT;
          end else if (pos + 3'd1 == seq_n) begin
            next_state = ST_MUTED;
            next_pos = 3'd0;
          end else begin
            next_pos = pos + 3'd1;
          end
        end else if (act != seq_mask(pos, dir, four)) begin
          next_state = ST_CLEARWAIT;
        end
      end
      ST_MUTED: begin
        // R18 the starting sensors end it; permit loss or the limit also end it
        if (!permit || mute_ms >= limit_ms) begin
          // R3 duration limit ends muting
          next_state = ST_CLEARWAIT;
        end else if (crossed) begin
          // R7 first release ends muting
          if (rel != 4'h0) begin
            next_state = ST_GRACE;
            restart = 1'b1;
          end
        end else if (rel != 4'h0) begin
          // R12 R16 ordered release
          if (pos == 3'd0 && rel == seq_mask(3'd1, 1'b0, four)) begin
            next_pos = 3'd1;
            next_dir = 1'b0;
          end else if (pos == 3'd0 && four &&
                       rel == seq_mask(3'd1, 1'b1, four)) begin
            next_pos = 3'd1;
            next_dir = 1'b1;
          end else if (pos != 3'd0 &&
                       rel == seq_mask(pos + 3'd1, dir, four)) begin
            next_pos = pos + 3'd1;
            if (pos + 3'd1 == seq_n) begin
              next_state = four ? ST_CLEARWAIT : ST_GRACE;
              restart = 1'b1;
            end
          end else if (pos == 3'd0 || rel != seq_mask(pos, dir, four)) begin
            next_state = ST_CLEARWAIT;
          end
        end
      end
      ST_GRACE: begin
        // R8 R13 check beams when grace runs out
        if (elapsed >= grace_ms) begin
          next_state = beam ? ST_TRIP : ST_CLEARWAIT;
        end
      end
      ST_CLEARWAIT: begin
        // R17 all sensors clear before next start
        if (act == 4'h0) begin
          next_state = ST_IDLE;
        end
      end
      ST_TRIP: begin
        // R9 override held until zone clear
        if (ovr && !beam) begin
          next_state = ST_CLEARWAIT;
        end
      end
      default: next_state = ST_BLOCKED;
    endcase
    // R19 fault or bad mode blocks
    if (fault || mode == MODE_BAD) begin
      next_state = ST_BLOCKED;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      pos <= 3'd0;
      dir <= 1'b0;
    end else begin
      state <= next_state;
      pos <= next_pos;
      dir <= next_dir;
    end
  end

  // step timer in ms
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      elapsed <= '0;
    end else if (restart) begin
      elapsed <= '0;
    end else if (tick && elapsed != '1) begin
      elapsed <= elapsed + 13'd1;
    end
  end

  // muting duration in ms
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mute_ms <= '0;
    end else if (state != ST_MUTED) begin
      mute_ms <= '0;
    end else if (tick) begin
      mute_ms <= mute_ms + 27'd1;
    end
  end

  // R6 suppression starts on entry, well inside latency
  always_comb begin
    case (next_state)
      ST_MUTED, ST_GRACE: next_on = 1'b1;
      ST_TRIP: next_on = ovr;
      ST_BLOCKED: next_on = 1'b0;
      default: next_on = !beam;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      safety_output_out <= 2'h0;
      muting_out <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      safety_output_out <= {next_on, next_on};
      muting_out <= (next_state == ST_MUTED);
      fault_out <= (next_state == ST_BLOCKED);
    end
  end

  blocked_off_a: assert property ( // R19
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_BLOCKED |-> safety_output_out == 2'h0 && fault_out)
    else $error("outputs on while blocked");
  fault_block_a: assert property ( // R19
    @(posedge clk_in) disable iff (sys_rst_in)
    fault |=> state == ST_BLOCKED)
    else $error("fault did not block");
  permit_gate_a: assert property ( // R21
    @(posedge clk_in) disable iff (sys_rst_in)
    !permit && state != ST_MUTED |=> !muting_out)
    else $error("muting without permit");
  mute_entry_a: assert property ( // R5
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(muting_out) |-> $past(act) == $past(used))
    else $error("muting without all sensors");
  cross_window_a: assert property ( // R5
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_ARMING && crossed && elapsed > CROSS_WIN_MS
    |=> !muting_out)
    else $error("crossed window exceeded");
  par_min_a: assert property ( // R11
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_ARMING && !crossed && pos == 3'd1 && elapsed < PAR_MIN_MS
    |=> !muting_out && pos != 3'd2)
    else $error("parallel gap too short");
  par2_order_a: assert property ( // R10
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_IDLE && mode == MODE_PAR2 && act == 4'h2
    |=> state == ST_CLEARWAIT)
    else $error("reverse start accepted");
  cross_end_a: assert property ( // R7
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_MUTED && crossed && rel != 4'h0 && !fault && permit &&
    mute_ms < limit_ms |=> state == ST_GRACE ##0 !muting_out)
    else $error("crossed release kept muting");
  grace_trip_a: assert property ( // R8
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_GRACE && elapsed >= grace_ms && beam && !fault
    |=> state == ST_TRIP && safety_output_out == {2{$past(ovr)}})
    else $error("no trip after grace");
  grace_on_a: assert property ( // R13
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_GRACE |-> safety_output_out == 2'h3)
    else $error("beams evaluated in grace");
  limit_end_a: assert property ( // R3
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_MUTED && mute_ms >= limit_ms |=> !muting_out)
    else $error("muting past limit");

  cross_mute_c: cover property (
    @(posedge clk_in) disable iff (sys_rst_in)
    crossed && $rose(muting_out));
  par4_mute_c: cover property (
    @(posedge clk_in) disable iff (sys_rst_in)
    four && $rose(muting_out));
  par2_grace_c: cover property (
    @(posedge clk_in) disable iff (sys_rst_in)
    mode == MODE_PAR2 && state == ST_MUTED ##1 state == ST_GRACE);
  trip_c: cover property (
    @(posedge clk_in) disable iff (sys_rst_in)
    state == ST_TRIP ##1 state == ST_CLEARWAIT);
endmodule : msc_sequencer

// ### msc_sensor_model.sv
// Purpose: far side of the muting sequencer, sensors and safety circuit
// Assumes: driven levels change only just after a rising clock edge
// Notes: released sensors sit low, the pins have pull-downs
`timescale 1ns/1ns
module msc_sensor_model (
  input wire logic clk_in,
  input wire logic [1:0] safety_output_in,
  output logic sensor_a_out,
  output logic sensor_b_out,
  output logic [3:0] arm_out,
  output logic permit_out,
  output logic [1:0] time_select_out,
  output logic split_out
);
  logic [5:0] lvl = 6'h00;
  logic permit = 1'b1;
  logic split = 1'b0;
  assign sensor_a_out = lvl[0];
  assign sensor_b_out = lvl[1];
  assign arm_out = lvl[5:2];
  assign permit_out = permit;
  assign time_select_out = 2'h0;
  assign split_out = split;
  // both channels must always agree
  always @(posedge clk_in) begin
    if (safety_output_in[0] !== safety_output_in[1]) begin
      split <= 1'b1;
    end
  end
  task automatic drive(input int i, input logic v);
    @(posedge clk_in);
    lvl[i] <= v;
  endtask : drive
  task automatic clear_all();
    @(posedge clk_in);
    lvl <= 6'h00;
  endtask : clear_all
  task automatic set_permit(input logic v);
    @(posedge clk_in);
    permit <= v;
  endtask : set_permit
endmodule : msc_sensor_model

// ### msc_sequencer_test.sv
// Purpose: self-checking bench of the muting sequencer
// Assumes: tick shortened to 2 clocks, so 1 ms is 2 clocks
// Notes: 24 h and selectable limits are too long to run here
`timescale 1ns/1ns
module msc_sequencer_test;
  import msc_pkg::*;
  localparam int TK = 2;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic beam = 1'b0;
  logic fault = 1'b0;
  logic ovr = 1'b0;
  logic [1:0] mode = 2'h0;
  logic sa, sb, permit, split;
  logic [3:0] arm;
  logic [1:0] tsel, safety;
  logic muting, flt;
  int error_cnt = 0;
  int n_tests = 0;

  always #25 clk_in = ~clk_in;

  msc_sequencer #(.TICK_CYC(TK)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .mute_sensor_a_in(sa), .mute_sensor_b_in(sb), .arm_sensor_in(arm),
    .mute_permit_in(permit), .beam_blocked_in(beam),
    .sensor_fault_in(fault), .override_in(ovr), .config_mode_in(mode),
    .selectable_time_in(1'b0), .time_select_in(tsel),
    .safety_output_out(safety), .muting_out(muting), .fault_out(flt)
  );

  msc_sensor_model pm (
    .clk_in(clk_in), .safety_output_in(safety), .sensor_a_out(sa),
    .sensor_b_out(sb), .arm_out(arm), .permit_out(permit),
    .time_select_out(tsel), .split_out(split)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic ms(input int n);
    cyc(n * TK);
  endtask : ms
  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic pins(input logic b, input logic o, input logic [1:0] m);
    @(posedge clk_in);
    beam <= b;
    ovr <= o;
    mode <= m;
    cyc(6);
  endtask : pins
  task automatic clear(input logic [1:0] m);
    pm.clear_all();
    pins(1'b0, 1'b0, m);
  endtask : clear
  task automatic try(input int f, input int s, input int gap, input logic e);
    pm.drive(f, 1'b1);
    ms(gap);
    pm.drive(s, 1'b1);
    cyc(6);
    chk("mute start", {1'b0, e}, {1'b0, muting});
    clear(mode);
    // crossed release runs a grace before the next start
    if (e && mode == 2'h0) begin
      ms(2010);
    end
  endtask : try

  task automatic crossed_trip();
    clear(2'h0);
    pm.drive(0, 1'b1);
    ms(1000);
    pm.drive(1, 1'b1);
    cyc(6);
    chk("cross mute", 2'h1, {1'b0, muting});
    pins(1'b1, 1'b0, 2'h0);
    chk("beam ignored", 2'h3, safety);
    pm.drive(0, 1'b0);
    cyc(6);
    chk("cross end", 2'h0, {1'b0, muting});
    ms(1985);
    chk("grace hold", 2'h3, safety);
    ms(25);
    chk("grace trip", 2'h0, safety);
    pins(1'b0, 1'b1, 2'h0);
    chk("override", 2'h3, safety);
    clear(2'h0);
  endtask : crossed_trip

  task automatic par2_trip();
    clear(2'h1);
    pm.drive(0, 1'b1);
    ms(1000);
    pm.drive(1, 1'b1);
    cyc(6);
    chk("par mute", 2'h1, {1'b0, muting});
    pins(1'b1, 1'b0, 2'h1);
    pm.drive(0, 1'b0);
    cyc(6);
    chk("par hold", 2'h1, {1'b0, muting});
    pm.drive(1, 1'b0);
    cyc(6);
    chk("par end", 2'h0, {1'b0, muting});
    ms(4985);
    chk("par grace", 2'h3, safety);
    ms(25);
    chk("par trip", 2'h0, safety);
    pins(1'b0, 1'b1, 2'h1);
    clear(2'h1);
  endtask : par2_trip

  task automatic par4(input bit rev);
    int k;
    clear(2'h2);
    for (k = 0; k < 4; k++) begin
      pm.drive(rev ? 5 - k : 2 + k, 1'b1);
      ms(k == 0 ? 500 : 50);
    end
    chk("four mute", 2'h1, {1'b0, muting});
    for (k = 0; k < 4; k++) begin
      pm.drive(rev ? 5 - k : 2 + k, 1'b0);
      ms(50);
    end
    chk("four end", 2'h0, {1'b0, muting});
    chk("four clear", 2'h3, safety);
  endtask : par4

  task automatic fault_block();
    @(posedge clk_in);
    fault <= 1'b1;
    cyc(6);
    chk("fault flag", 2'h1, {1'b0, flt});
    chk("fault off", 2'h0, safety);
    @(posedge clk_in);
    fault <= 1'b0;
    cyc(6);
    chk("fault sticky", 2'h1, {1'b0, flt});
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    cyc(8);
    chk("fault reset", 2'h0, {1'b0, flt});
    pins(1'b0, 1'b0, 2'h3);
    chk("bad mode", 2'h1, {1'b0, flt});
    chk("bad mode off", 2'h0, safety);
  endtask : fault_block

  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    crossed_trip();
    try(0, 1, 2100, 1'b0);
    try(1, 0, 500, 1'b1);
    par2_trip();
    try(1, 0, 1000, 1'b0);
    try(0, 1, 280, 1'b0);
    try(0, 1, 320, 1'b1);
    try(0, 1, 5100, 1'b0);
    try(0, 1, 4900, 1'b1);
    try(2, 1, 1000, 1'b1);
    pm.set_permit(1'b0);
    try(0, 1, 1000, 1'b0);
    pm.set_permit(1'b1);
    par4(1'b0);
    par4(1'b1);
    clear(2'h2);
    try(2, 4, 500, 1'b0);
    try(2, 3, 100, 1'b0);
    fault_block();
    chk("pair agree", 2'h0, {1'b0, split});
    end_of_test();
  end

  // watchdog, well beyond the expected run
  initial begin
    #4500000;
    error_cnt++;
    end_of_test();
  end
endmodule : msc_sequencer_test
